// ---- rtl/hbridge_pkg.sv ----
// constants and types shared by the bridge gate control block
package hbridge_pkg;
  // clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  // disable pulse timing, nanoseconds as printed (3.1 us, 3.6 us, 7 us)
  localparam int unsigned CLEAR_MIN_NS    = 3100;
  localparam int unsigned CLEAR_MAX_NS    = 3600;
  localparam int unsigned OFF_MIN_NS      = 7000;
  // least times round up, longest round down
  localparam int unsigned CLEAR_MIN_CYC   = (CLEAR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CLEAR_MAX_CYC   = CLEAR_MAX_NS / CLK_NS;
  localparam int unsigned OFF_MIN_CYC     = (OFF_MIN_NS + CLK_NS - 1) / CLK_NS;
  // width of the high-time counter
  localparam int unsigned HIGH_CNT_W      = 9;
  localparam logic [HIGH_CNT_W-1:0] HIGH_CNT_MAX = 9'h1ff;
  // register reset values
  localparam logic        FLAG_RST        = 1'b1;
  localparam logic        GATE_RST        = 1'b0;
  localparam logic [3:0]  IRQ_RST         = 4'h0;
  // register map of the plain port
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_PEND   = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h8;
  localparam logic [3:0]  ADDR_CONTROL    = 4'hc;
  // bit positions of events in pending and mask
  localparam int unsigned EV_SHORT_A      = 0;
  localparam int unsigned EV_SHORT_B      = 1;
  localparam int unsigned EV_LOW_SUPPLY   = 2;
  localparam int unsigned EV_HOT          = 3;
  // disable pin interpreter states
  typedef enum logic [2:0] {
    DIS_IDLE = 3'b001,
    DIS_HIGH = 3'b010,
    DIS_OFF  = 3'b100
  } dis_state_type;
endpackage : hbridge_pkg

// ---- rtl/half_bridge_stage.sv ----
// one half-bridge: latched short shutdown and undervoltage masking
`timescale 1ns/100ps
module half_bridge_stage
  import hbridge_pkg::*;
(
  input  wire logic clk_i,           // system clock
  input  wire logic rst_i,           // async reset, active high
  input  wire logic want_upper_i,    // demanded upper gate
  input  wire logic want_lower_i,    // demanded lower gate
  input  wire logic short_i,         // short detected on this stage
  input  wire logic low_upper_i,     // undervoltage on upper drive
  input  wire logic low_lower_i,     // undervoltage on lower drive
  input  wire logic clear_i,         // clear latched short
  output logic      upper_o,         // gate command, combinational
  output logic      lower_o,         // gate command, combinational
  output logic      latched_o        // short latch state
);
  logic short_latch;                 // held until a clear pulse
  wire  next_short = short_i | (short_latch & ~clear_i);  // set wins

  // short latch, only a clear pulse or reset releases it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      short_latch <= 1'b0;
    end else begin
      short_latch <= next_short;     // [R5]
    end
  end

  // affected gates forced off, others keep following
  assign upper_o   = want_upper_i & ~short_latch & ~low_upper_i;  // [R2] [R5]
  assign lower_o   = want_lower_i & ~short_latch & ~low_lower_i;  // [R2] [R5]
  assign latched_o = short_latch;
endmodule : half_bridge_stage

// ---- rtl/hbridge_gate_control_logic.sv ----
// gate control logic of a full-bridge driver with two-bit diagnosis
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// R1: direction and pulse map onto four gates
// R2: undervoltage gates off, auto-recover
// R3: undervoltage mismatch pulls shutdown flag low
// R4: undervoltage drives cause flag low
// R5: short latches its half-bridge off
// R6: short mismatch: shutdown low, cause high
// R7: controller modulates direction for fast decay
// R8: overtemperature: cause low, gates normal
// R9: disable high over 7 us: all off
// R10: disable pulse in window clears latches
module hbridge_gate_control_logic
  import hbridge_pkg::*;
(
  input  wire logic        clk_i,              // system clock 50 MHz
  input  wire logic        rst_i,              // async reset, active high
  input  wire logic        direction_i,        // spin direction
  input  wire logic        pulse_i,            // pulse-width input
  input  wire logic        delay_and_off_in_i, // disable pin above threshold
  input  wire logic [3:0]  low_supply_cond_i,  // undervoltage: ua, la, ub, lb
  input  wire logic        hot_warning_cond_i, // overtemperature warning
  input  wire logic [1:0]  shorted_stage_cond_i, // short per half-bridge a, b
  input  wire logic [3:0]  addr_i,             // register byte address
  input  wire logic [31:0] wdata_i,            // write data
  input  wire logic        wr_i,               // write strobe
  input  wire logic        rd_i,               // read strobe
  output logic [31:0]      rdata_o,            // read data, cycle after strobe
  output logic             irq_o,              // level interrupt
  output logic             upper_gate_a_o,     // upper gate a
  output logic             lower_gate_a_o,     // lower gate a
  output logic             upper_gate_b_o,     // upper gate b
  output logic             lower_gate_b_o,     // lower gate b
  output logic             shutdown_flag_n_o,  // open-drain level, low = shutdown
  output logic             shutdown_flag_oe_o, // drives low while high
  output logic             cause_flag_n_o,     // open-drain level, low = cause
  output logic             cause_flag_oe_o     // drives low while high
);
  import hbridge_pkg::*;

  // disable pin interpreter
  dis_state_type            dis_state;          // current state
  dis_state_type            next_dis_state;     // next state
  logic [HIGH_CNT_W-1:0]    high_cnt;           // cycles disable held high
  logic                     clear_pulse;        // one-cycle latch clear
  logic                     all_off;            // outputs disabled
  logic                     sw_off;             // software disable bit

  // register file
  logic [3:0]               irq_pend;           // sticky event bits
  logic [3:0]               irq_mask;           // interrupt enables
  logic [1:0]               prev_short;         // latch state last cycle
  logic                     prev_low;           // undervoltage last cycle
  logic                     prev_hot;           // overtemperature last cycle

  // half-bridge outputs
  logic                     ua, la, ub, lb;     // gated commands
  logic [1:0]               latched;            // short latch states

  // input mapping of the normal truth table
  wire want_ua = ~pulse_i | ~direction_i;       // [R1] [R7]
  wire want_la =  pulse_i &  direction_i;       // [R1] [R7]
  wire want_ub = ~pulse_i |  direction_i;       // [R1]
  wire want_lb =  pulse_i & ~direction_i;       // [R1]

  // time of disable high, saturating
  wire [HIGH_CNT_W-1:0] next_cnt = (high_cnt == HIGH_CNT_MAX) ? high_cnt
                                   : high_cnt + 9'h001;
  wire in_clear_window = (high_cnt >= CLEAR_MIN_CYC[HIGH_CNT_W-1:0]) &&
                         (high_cnt <= CLEAR_MAX_CYC[HIGH_CNT_W-1:0]);
  wire reach_off = (high_cnt >= OFF_MIN_CYC[HIGH_CNT_W-1:0]);

  // state transitions of the disable interpreter
  always_comb begin
    next_dis_state = dis_state;
    unique case (dis_state)
      DIS_IDLE: begin
        if (delay_and_off_in_i) begin
          next_dis_state = DIS_HIGH;
        end
      end
      DIS_HIGH: begin
        if (!delay_and_off_in_i) begin
          next_dis_state = DIS_IDLE;     // pulse ended
        end else if (reach_off) begin
          next_dis_state = DIS_OFF;      // [R9]
        end
      end
      DIS_OFF: begin
        if (!delay_and_off_in_i) begin
          next_dis_state = DIS_IDLE;
        end
      end
      default: next_dis_state = DIS_IDLE;  // illegal one-hot code
    endcase
  end

  // clear on falling edge of a pulse inside the window
  wire next_clear = (dis_state == DIS_HIGH) & ~delay_and_off_in_i &
                    in_clear_window;     // [R10]

  // disable interpreter registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dis_state   <= DIS_IDLE;
      high_cnt    <= '0;
      clear_pulse <= 1'b0;
    end else begin
      dis_state   <= next_dis_state;
      high_cnt    <= delay_and_off_in_i ? next_cnt : '0;
      clear_pulse <= next_clear;
    end
  end

  // a short clear pulse never shuts outputs down
  assign all_off = (dis_state == DIS_OFF) | sw_off;  // [R9] [R10]

  // half-bridge a
  half_bridge_stage stage_a (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .want_upper_i (want_ua),
    .want_lower_i (want_la),
    .short_i      (shorted_stage_cond_i[0]),
    .low_upper_i  (low_supply_cond_i[0]),
    .low_lower_i  (low_supply_cond_i[1]),
    .clear_i      (clear_pulse),
    .upper_o      (ua),
    .lower_o      (la),
    .latched_o    (latched[0])
  );

  // half-bridge b
  half_bridge_stage stage_b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .want_upper_i (want_ub),
    .want_lower_i (want_lb),
    .short_i      (shorted_stage_cond_i[1]),
    .low_upper_i  (low_supply_cond_i[2]),
    .low_lower_i  (low_supply_cond_i[3]),
    .clear_i      (clear_pulse),
    .upper_o      (ub),
    .lower_o      (lb),
    .latched_o    (latched[1])
  );

  // diagnosis decode
  wire mismatch   = (ua != want_ua) | (la != want_la) |
                    (ub != want_ub) | (lb != want_lb);
  wire low_any    = |low_supply_cond_i;
  wire next_sd_n  = ~(mismatch & ~all_off);          // [R3] [R6]
  wire next_cause_n = all_off ? 1'b1
                    : low_any ? 1'b0                 // [R4]
                    : (|latched) ? 1'b1              // [R6]
                    : ~hot_warning_cond_i;           // [R8]

  // gate and flag outputs, all registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      upper_gate_a_o    <= GATE_RST;
      lower_gate_a_o    <= GATE_RST;
      upper_gate_b_o    <= GATE_RST;
      lower_gate_b_o    <= GATE_RST;
      shutdown_flag_n_o <= FLAG_RST;
      cause_flag_n_o    <= FLAG_RST;
    end else begin
      upper_gate_a_o    <= ua & ~all_off;  // [R9]
      lower_gate_a_o    <= la & ~all_off;  // [R9]
      upper_gate_b_o    <= ub & ~all_off;  // [R9]
      lower_gate_b_o    <= lb & ~all_off;  // [R9]
      shutdown_flag_n_o <= next_sd_n;
      cause_flag_n_o    <= next_cause_n;
    end
  end

  // open-drain enables track the low level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shutdown_flag_oe_o <= 1'b0;
      cause_flag_oe_o    <= 1'b0;
    end else begin
      shutdown_flag_oe_o <= ~next_sd_n;
      cause_flag_oe_o    <= ~next_cause_n;
    end
  end

  // register decode
  wire wr_pend = wr_i & (addr_i == ADDR_IRQ_PEND);
  wire wr_mask = wr_i & (addr_i == ADDR_IRQ_MASK);
  wire wr_ctrl = wr_i & (addr_i == ADDR_CONTROL);
  wire [3:0] events = {hot_warning_cond_i & ~prev_hot,
                       low_any & ~prev_low,
                       latched & ~prev_short};
  // set wins over write-one-to-clear
  wire [3:0] next_pend = events | (irq_pend & ~(wr_pend ? wdata_i[3:0] : 4'h0));
  wire [31:0] status_word = {25'h000_0000, all_off, hot_warning_cond_i, low_any,
                             latched, dis_state == DIS_OFF, sw_off};
  wire [31:0] read_mux = (addr_i == ADDR_STATUS)   ? status_word
                       : (addr_i == ADDR_IRQ_PEND) ? {28'h000_0000, irq_pend}
                       : (addr_i == ADDR_IRQ_MASK) ? {28'h000_0000, irq_mask}
                       : (addr_i == ADDR_CONTROL)  ? {31'h0000_0000, sw_off}
                       : 32'h0000_0000;

  // event history for edge detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_short <= 2'b00;
      prev_low   <= 1'b0;
      prev_hot   <= 1'b0;
    end else begin
      prev_short <= latched;
      prev_low   <= low_any;
      prev_hot   <= hot_warning_cond_i;
    end
  end

  // software registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_pend <= IRQ_RST;
      irq_mask <= IRQ_RST;
      sw_off   <= 1'b0;
    end else begin
      irq_pend <= next_pend;
      irq_mask <= wr_mask ? wdata_i[3:0] : irq_mask;
      sw_off   <= wr_ctrl ? wdata_i[0] : sw_off;
    end
  end

  // read data and interrupt line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
      irq_o   <= 1'b0;
    end else begin
      rdata_o <= rd_i ? read_mux : 32'h0000_0000;
      irq_o   <= |(next_pend & irq_mask);
    end
  end
endmodule : hbridge_gate_control_logic

// ---- tb/ctrl_model.sv ----
// controller model driving the direction and pulse inputs
`timescale 1ns/100ps
module ctrl_model (
  input  wire logic clk_i,              // system clock
  input  wire logic fast_i,             // fast decay mode
  input  wire logic spin_i,             // wanted direction
  input  wire logic duty_i,             // modulation level
  output logic      direction_o = 1'b0, // to direction input
  output logic      pulse_o = 1'b0      // to pulse input
);
  // fast decay holds pulse high and modulates direction
  always_ff @(posedge clk_i) begin
    if (fast_i) begin
      pulse_o     <= 1'b1;
      direction_o <= duty_i;
    end else begin
      pulse_o     <= duty_i;
      direction_o <= spin_i;
    end
  end
endmodule : ctrl_model

// ---- tb/hbridge_props.sv ----
// assertion checker of the bridge gate control block
`timescale 1ns/100ps
module hbridge_props
  import hbridge_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        direction_i,
  input wire logic        pulse_i,
  input wire logic        delay_and_off_in_i,
  input wire logic [3:0]  low_supply_cond_i,
  input wire logic        hot_warning_cond_i,
  input wire logic [1:0]  shorted_stage_cond_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        upper_gate_a_o,
  input wire logic        lower_gate_a_o,
  input wire logic        upper_gate_b_o,
  input wire logic        lower_gate_b_o,
  input wire logic        shutdown_flag_n_o,
  input wire logic        shutdown_flag_oe_o,
  input wire logic        cause_flag_n_o,
  input wire logic        cause_flag_oe_o
);
  // demanded gates, order lower b, upper b, lower a, upper a
  function automatic logic [3:0] dm(input logic d, input logic p);
    return !p ? 4'h5 : (d ? 4'h6 : 4'h9);
  endfunction : dm
  wire [3:0] gv = {lower_gate_b_o, upper_gate_b_o, lower_gate_a_o, upper_gate_a_o};
  logic [HIGH_CNT_W-1:0] hi; // disable pin high time in cycles
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // consecutive high cycles of the disable pin, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi <= '0;
    end else if (!delay_and_off_in_i) begin
      hi <= '0;
    end else if (hi != HIGH_CNT_MAX) begin
      hi <= hi + 1'b1;
    end
  end
  a_gates_match: assert property (
    gv != 4'h0 |-> shutdown_flag_n_o == (gv == dm($past(direction_i), $past(pulse_i))))
    else $error("gate pattern and shutdown flag disagree");
  a_supply_mask: assert property (
    low_supply_cond_i != 4'h0 |=> (gv & $past(low_supply_cond_i)) == 4'h0)
    else $error("gate on during undervoltage");
  a_supply_cause: assert property (
    low_supply_cond_i != 4'h0 && !delay_and_off_in_i && hi == 0 |=> !cause_flag_n_o)
    else $error("cause flag high during undervoltage");
  a_short_latch: assert property (
    shorted_stage_cond_i[0] && low_supply_cond_i == 4'h0 ##1 low_supply_cond_i == 4'h0
    |=> !upper_gate_a_o && !lower_gate_a_o && cause_flag_n_o)
    else $error("short did not shut half a");
  a_hot_cause: assert property (
    hot_warning_cond_i && low_supply_cond_i == 4'h0 ##1 shutdown_flag_n_o && gv != 4'h0
    |-> !cause_flag_n_o)
    else $error("cause flag high during hot warning");
  a_long_off: assert property (
    hi > OFF_MIN_CYC + 3 |-> gv == 4'h0 && shutdown_flag_n_o && cause_flag_n_o)
    else $error("gates on after long disable");
  a_pulse_keeps: assert property (
    delay_and_off_in_i && hi < CLEAR_MAX_CYC && shutdown_flag_n_o |-> gv != 4'h0)
    else $error("short disable pulse shut gates");
  a_drive_enables: assert property (
    shutdown_flag_oe_o == !shutdown_flag_n_o && cause_flag_oe_o == !cause_flag_n_o)
    else $error("flag enable disagrees with flag");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data without read");
  cover property (shorted_stage_cond_i[0]);
  cover property (hi > OFF_MIN_CYC + 3);
  cover property (hot_warning_cond_i && gv != 4'h0);
  cover property (!delay_and_off_in_i && hi >= CLEAR_MIN_CYC && hi <= CLEAR_MAX_CYC);
endmodule : hbridge_props
bind hbridge_gate_control_logic hbridge_props chk (.*);

// ---- tb/hbridge_gate_control_logic_test.sv ----
// testbench of the bridge gate control block
`timescale 1ns/100ps
module hbridge_gate_control_logic_test;
  import hbridge_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, fast = 1'b0, spin = 1'b0, duty = 1'b1;
  logic dis = 1'b0, hot = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] low = 4'h0, addr = 4'h0;
  logic [1:0] shrt = 2'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic dir, pls, irq, ua, la, ub, lb, sf, so, cf, co;
  int failures = 0, tests_run = 0, cycles = 0;
  wire [3:0] gv = {lb, ub, la, ua};
  wire [1:0] fl = {sf, cf};
  ctrl_model ctl (.clk_i(clk_i), .fast_i(fast), .spin_i(spin), .duty_i(duty),
    .direction_o(dir), .pulse_o(pls));
  hbridge_gate_control_logic dut (.clk_i(clk_i), .rst_i(rst_i), .direction_i(dir),
    .pulse_i(pls), .delay_and_off_in_i(dis), .low_supply_cond_i(low),
    .hot_warning_cond_i(hot), .shorted_stage_cond_i(shrt), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .upper_gate_a_o(ua), .lower_gate_a_o(la), .upper_gate_b_o(ub),
    .lower_gate_b_o(lb), .shutdown_flag_n_o(sf), .shutdown_flag_oe_o(so),
    .cause_flag_n_o(cf), .cause_flag_oe_o(co));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // settle through model and gates, compare, return on a rising edge
  task automatic look(input logic [3:0] g, input logic [1:0] f);
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk("gates", {28'h0, gv}, {28'h0, g});
    chk("flags", {30'h0, fl}, {30'h0, f});
    chk("enables", {30'h0, so, co}, {30'h0, ~f});
    @(posedge clk_i);
  endtask : look
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irq_is
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd   <= 1'b0;
    @(negedge clk_i);
    chk("read data", rdata, e);
  endtask : rd_reg
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      spin <= i[1];
      duty <= i[0];
      look(!i[0] ? 4'h5 : (i[1] ? 4'h6 : 4'h9), 2'b11);
    end
    fast <= 1'b1;
    look(4'h6, 2'b11);
    duty <= 1'b0;
    look(4'h9, 2'b11);
    fast <= 1'b0;
    spin <= 1'b0;
    duty <= 1'b1;
    low  <= 4'h1;
    look(4'h8, 2'b00);
    low <= 4'h0;
    look(4'h9, 2'b11);
    hot <= 1'b1;
    look(4'h9, 2'b10);
    hot  <= 1'b0;
    shrt <= 2'b01;
    @(posedge clk_i);
    shrt <= 2'b00;
    look(4'h8, 2'b01);
    spin <= 1'b1;
    look(4'h4, 2'b01);
    rd_reg(ADDR_STATUS, 32'h0000_0004);
    rd_reg(ADDR_IRQ_PEND, 32'h0000_000d);
    irq_is(1'b0);
    wr_reg(ADDR_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr_reg(ADDR_IRQ_PEND, 32'h0000_000d);
    irq_is(1'b0);
    rd_reg(ADDR_IRQ_MASK, 32'h0000_0001);
    rd_reg(4'h2, 32'h0000_0000);
    @(posedge clk_i);
    dis <= 1'b1;
    repeat (100) @(posedge clk_i);
    @(negedge clk_i);
    chk("gates", {28'h0, gv}, 32'h0000_0004);
    repeat (65) @(posedge clk_i);
    dis <= 1'b0;
    look(4'h6, 2'b11);
    dis <= 1'b1;
    repeat (380) @(posedge clk_i);
    look(4'h0, 2'b11);
    dis <= 1'b0;
    look(4'h6, 2'b11);
    // software disable bit turns every gate off and shows in status
    wr_reg(ADDR_CONTROL, 32'h0000_0001);
    look(4'h0, 2'b11);
    rd_reg(ADDR_STATUS, 32'h0000_0041);
    rd_reg(ADDR_CONTROL, 32'h0000_0001);
    wr_reg(ADDR_CONTROL, 32'h0000_0000);
    look(4'h6, 2'b11);
    end_sim();
  end
endmodule : hbridge_gate_control_logic_test
